// ==== hw/cosim_clock_pkg.sv ====
// Constants shared by the co-simulation clock stepper and its rate generator
package cosim_clock_pkg;
    // Reference clock figures
    localparam int REF_CLK_MHZ = 100;
    localparam int REF_CLK_PERIOD_NS = 10;
    // Frequencies in units of one sixth of 100 MHz (about 16.67 MHz)
    localparam int FREQ_100_U = 6;
    localparam int FREQ_66_7_U = 4;
    localparam int FREQ_50_U = 3;
    localparam int FREQ_33_3_U = 2;
    localparam int SYS_100_U = 6;
    localparam int SYS_200_U = 12;
    localparam int ACC_W = 5;
    // Host map: port words at low indices, status word at a fixed index
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] STATUS_IDX = 4'hF;
    localparam int ST_FLAG = 0;
    localparam int ST_BUSY = 1;
    localparam int ST_MODE = 2;
    localparam int ST_RUN = 3;
    localparam int CNT_W = 8;
    typedef enum logic {STEP_IDLE, STEP_RUN} step_e;
endpackage : cosim_clock_pkg

// ==== hw/clock_rate_gen.sv ====
// Fractional clock-enable generator deriving the design clock rate
`timescale 1ns/10ps
module clock_rate_gen #(
    parameter int SYS_U = cosim_clock_pkg::SYS_100_U,
    parameter int TGT_U = cosim_clock_pkg::FREQ_50_U
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic ce,
    output logic tick
);
    import cosim_clock_pkg::*;

    typedef struct packed {
        logic [ACC_W-1:0] acc;
        logic tick;
    } rate_s;

    rate_s q;
    rate_s d;
    logic [ACC_W-1:0] sum;

    initial begin
        if (TGT_U > SYS_U || TGT_U < 1 || SYS_U >= (1 << (ACC_W - 1))) begin
            $error("clock_rate_gen: unsupported rate setting");
        end
    end

    // Accumulator pattern is fixed, so every run gives the same enable sequence
    always_comb begin
        d = q;
        sum = q.acc + ACC_W'(TGT_U);
        d.tick = 1'b0;
        d.acc = sum;
        if (sum >= ACC_W'(SYS_U)) begin
            d.tick = 1'b1;
            d.acc = sum - ACC_W'(SYS_U);
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign tick = q.tick;
endmodule : clock_rate_gen

// ==== hw/cosim_clock_stepper.sv ====
// Design-clock control and host port map for a co-simulated design
`timescale 1ns/10ps
module cosim_clock_stepper #(
    parameter int SYS_U = cosim_clock_pkg::SYS_100_U,
    parameter int TGT_U = cosim_clock_pkg::FREQ_50_U,
    parameter bit FREE_OK = 1'b1,
    parameter int STEP_PULSES = 1,
    parameter int N_IN = 2,
    parameter int N_OUT = 2,
    parameter int DATA_W = 32,
    parameter int PAD_W = 4
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic run,
    input wire logic mode_free_sel,
    input wire logic step_req,
    output logic step_busy,
    output logic step_done,
    input wire logic host_req,
    input wire logic host_we,
    input wire logic [cosim_clock_pkg::ADDR_W-1:0] host_addr,
    input wire logic [DATA_W-1:0] host_wdata,
    output logic [DATA_W-1:0] host_rdata,
    output logic host_ack,
    output logic dut_ce,
    output logic [N_IN-1:0][DATA_W-1:0] dut_in,
    input wire logic [N_OUT-1:0][DATA_W-1:0] dut_out,
    input wire logic dut_flag,
    input wire logic [PAD_W-1:0] pad_in,
    output logic [PAD_W-1:0] pad_to_dut,
    input wire logic [PAD_W-1:0] pad_from_dut,
    output logic [PAD_W-1:0] pad_out
);
    import cosim_clock_pkg::*;

    typedef struct packed {
        step_e st;
        logic running;
        logic mode_free;
        logic flag;
        logic [CNT_W-1:0] cnt;
        logic done;
        logic ack;
        logic [DATA_W-1:0] rdata;
        logic [N_IN-1:0][DATA_W-1:0] in_regs;
    } ctl_s;

    ctl_s q;
    ctl_s d;
    logic rate_tick;
    logic access_ok;

    initial begin
        if (TGT_U > SYS_U) begin
            $error("cosim_clock_stepper: design clock above system clock");
        end
        if (STEP_PULSES < 1 || STEP_PULSES >= (1 << CNT_W)) begin
            $error("cosim_clock_stepper: bad step pulse count");
        end
        if (N_IN < 1 || N_OUT < 1 || N_IN >= int'(STATUS_IDX) || N_OUT >= int'(STATUS_IDX)) begin
            $error("cosim_clock_stepper: port count collides with status word");
        end
        if (DATA_W < 4) begin
            $error("cosim_clock_stepper: data word too narrow for status");
        end
    end

    function automatic logic [DATA_W-1:0] read_word(
        input logic [ADDR_W-1:0] addr,
        input logic [N_OUT-1:0][DATA_W-1:0] outs,
        input ctl_s s
    );
        logic [DATA_W-1:0] w;
        w = '0;
        if (addr == STATUS_IDX) begin
            w[ST_FLAG] = s.flag;
            w[ST_BUSY] = (s.st == STEP_RUN);
            w[ST_MODE] = s.mode_free;
            w[ST_RUN] = s.running;
        end else if (int'(addr) < N_OUT) begin
            w = outs[addr];
        end
        return w;
    endfunction : read_word

    clock_rate_gen #(
        .SYS_U(SYS_U),
        .TGT_U(TGT_U)
    ) u_rate (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .ce(ce),
        .tick(rate_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Control and host map

    // Stepping mode blocks host access so port updates fall between steps only
    assign access_ok = host_req && !q.ack && !(!q.mode_free && q.st == STEP_RUN);

    always_comb begin
        d = q;
        d.ack = 1'b0;
        d.done = 1'b0;
        d.running = run;
        if (!run) begin
            d.mode_free = mode_free_sel && FREE_OK;
            d.st = STEP_IDLE;
        end
        case (q.st)
            STEP_IDLE: begin
                if (step_req && q.running && run && !q.mode_free) begin
                    d.st = STEP_RUN;
                    d.cnt = '0;
                end
            end
            STEP_RUN: begin
                if (rate_tick) begin
                    if (q.cnt == CNT_W'(STEP_PULSES - 1)) begin
                        d.st = STEP_IDLE;
                        d.done = 1'b1;
                    end else begin
                        d.cnt = q.cnt + 1'b1;
                    end
                end
            end
            default: begin
                d.st = STEP_IDLE;
            end
        endcase
        if (access_ok) begin
            d.ack = 1'b1;
            if (host_we) begin
                if (int'(host_addr) < N_IN) begin
                    d.in_regs[host_addr] = host_wdata;
                end else if (host_addr == STATUS_IDX && host_wdata[ST_FLAG]) begin
                    d.flag = 1'b0;
                end
            end else begin
                d.rdata = read_word(host_addr, dut_out, q);
            end
        end
        // A new event beats a clear in the same cycle
        if (dut_flag) begin
            d.flag = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    // Enable only, so the design sees whole clock cycles or none
    assign dut_ce = ce && rate_tick && q.running
        && (q.mode_free || q.st == STEP_RUN);
    assign step_busy = (q.st == STEP_RUN);
    assign step_done = q.done;
    assign host_ack = q.ack;
    assign host_rdata = q.rdata;
    assign dut_in = q.in_regs;
    // Pads bypass the host map entirely
    assign pad_to_dut = pad_in;
    assign pad_out = pad_from_dut;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    logic [CNT_W-1:0] pulse_seen_q;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pulse_seen_q <= '0;
        end else if (ce) begin
            if (q.st == STEP_IDLE) begin
                pulse_seen_q <= '0;
            end else if (dut_ce) begin
                pulse_seen_q <= pulse_seen_q + 1'b1;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence step_start_s;
        ce && q.st == STEP_IDLE && step_req && q.running && run && !q.mode_free;
    endsequence

    sequence step_busy_s;
        step_busy[*1];
    endsequence

    step_count_a: assert property (
        step_done |-> pulse_seen_q == CNT_W'(STEP_PULSES))
        else $error("step issued wrong pulse count");
    step_start_a: assert property (
        step_start_s |=> step_busy_s)
        else $error("step request not taken");
    held_stop_a: assert property (
        !q.mode_free && q.st == STEP_IDLE |-> !dut_ce)
        else $error("clock ran between steps");
    free_runs_a: assert property (
        q.mode_free && q.running && ce && rate_tick |-> dut_ce)
        else $error("free clock missed a tick");
    mode_hold_a: assert property (
        q.running && run && ce |=> $stable(q.mode_free))
        else $error("mode changed during run");
    no_free_a: assert property (
        !FREE_OK |-> !q.mode_free)
        else $error("free mode on unsupported board");
    flag_sticky_a: assert property (
        ce && dut_flag |=> q.flag)
        else $error("status flag event lost");
    write_now_a: assert property (
        ce && q.mode_free && access_ok && host_we && int'(host_addr) < N_IN
        |=> host_ack && dut_in[$past(host_addr)] == $past(host_wdata))
        else $error("host write not applied at once");
    step_wait_a: assert property (
        !q.mode_free && step_busy |-> !access_ok)
        else $error("host access during step");
    rate_cap_a: assert property (
        TGT_U * 2 <= SYS_U && ce && rate_tick |=> !rate_tick)
        else $error("design clock above selected rate");
endmodule : cosim_clock_stepper

// ==== testbench/host_model.sv ====
// Host-side partner issuing one-word port map accesses
`timescale 1ns/10ps
module host_model #(
    parameter int DATA_W = 32
) (
    input wire logic ref_clk,
    output logic host_req,
    output logic host_we,
    output logic [cosim_clock_pkg::ADDR_W-1:0] host_addr,
    output logic [DATA_W-1:0] host_wdata,
    input wire logic [DATA_W-1:0] host_rdata,
    input wire logic host_ack
);
    initial begin
        host_req = 1'b0;
        host_we = 1'b0;
        host_addr = '0;
        host_wdata = '0;
    end
    // Held until ack; a stalled step blocks us, so the wait is bounded
    task automatic access(input logic we, input logic [3:0] addr,
            input logic [DATA_W-1:0] wdata, output logic [DATA_W-1:0] rdata,
            output bit ok);
        ok = 1'b0;
        rdata = '0;
        @(negedge ref_clk);
        host_req = 1'b1;
        host_we = we;
        host_addr = addr;
        host_wdata = wdata;
        for (int n = 0; n < 200 && !ok; n++) begin
            @(negedge ref_clk);
            if (host_ack === 1'b1) begin
                ok = 1'b1;
                rdata = host_rdata;
            end
        end
        host_req = 1'b0;
        // Released lines must not keep showing the old value
        host_wdata = ~wdata;
        host_addr = ~addr;
    endtask : access
endmodule : host_model

// ==== testbench/cosim_clock_stepper_tb_top.sv ====
// Self-checking bench for the co-simulation clock stepper
`timescale 1ns/10ps
module cosim_clock_stepper_tb_top;
    import cosim_clock_pkg::*;
    localparam int SP = 2;
    logic ref_clk, nrst, ce, run, mode_free_sel, step_req, dut_flag;
    logic step_busy, step_done, host_req, host_we, host_ack, dut_ce;
    logic [ADDR_W-1:0] host_addr;
    logic [31:0] host_wdata, host_rdata, seed, rd;
    logic [31:0] exp_in [2];
    logic [1:0][31:0] dut_in, dut_out;
    logic [3:0] pad_in, pad_to_dut, pad_from_dut, pad_out;
    int fails, checks, ce_cnt, base, n;
    bit ok;

    cosim_clock_stepper #(.SYS_U(SYS_100_U), .TGT_U(FREQ_50_U), .STEP_PULSES(SP))
    cosim_clock_stepper_inst (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .run(run),
        .mode_free_sel(mode_free_sel), .step_req(step_req), .step_busy(step_busy),
        .step_done(step_done), .host_req(host_req), .host_we(host_we),
        .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
        .host_ack(host_ack), .dut_ce(dut_ce), .dut_in(dut_in), .dut_out(dut_out),
        .dut_flag(dut_flag), .pad_in(pad_in), .pad_to_dut(pad_to_dut),
        .pad_from_dut(pad_from_dut), .pad_out(pad_out));
    host_model host_model_inst (.ref_clk(ref_clk), .host_req(host_req),
        .host_we(host_we), .host_addr(host_addr), .host_wdata(host_wdata),
        .host_rdata(host_rdata), .host_ack(host_ack));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic acc(input logic we, input logic [3:0] a, input logic [31:0] d);
        host_model_inst.access(we, a, d, rd, ok);
        chk({31'h0, ok}, 32'h1);
    endtask : acc
    task automatic cycles(input int k);
        repeat (k) @(negedge ref_clk);
    endtask : cycles
    task automatic close_out();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out

    ////////////////////////////////////////////////////////////////////////////////
    // Nonblocking so a snapshot at a falling edge never races the count
    always @(negedge ref_clk) begin
        if (dut_ce === 1'b1) begin
            ce_cnt <= ce_cnt + 1;
        end
    end
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        #50000;
        fails++;
        close_out();
    end
    initial begin
        {nrst, run, mode_free_sel, step_req, dut_flag, ce} = 6'h01;
        {dut_out, pad_in, pad_from_dut} = '0;
        seed = 32'hF8A97BBD;
        exp_in = '{32'h0, 32'h0};
        cycles(5);
        chk({28'h0, dut_ce, step_busy, step_done, host_ack}, 32'h0);
        chk(dut_in[0] | dut_in[1], 32'h0);
        nrst = 1'b1;
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            pad_in = seed[3:0];
            pad_from_dut = seed[7:4];
            dut_out[i%2] = ~seed;
            #1 chk({24'h0, pad_out, pad_to_dut}, {24'h0, seed[7:0]});
            acc(1'b1, 4'(i % 2), seed);
            exp_in[i%2] = seed;
            chk(dut_in[0], exp_in[0]);
            chk(dut_in[1], exp_in[1]);
            acc(1'b0, 4'(i % 2), 32'h0);
            chk(rd, ~seed);
        end
        acc(1'b1, 4'h7, seed);
        chk(dut_in[0] ^ dut_in[1], exp_in[0] ^ exp_in[1]);
        acc(1'b0, 4'h5, 32'h0);
        chk(rd, 32'h0);
        run = 1'b1;
        cycles(3);
        for (int k = 0; k < 3; k++) begin
            base = ce_cnt;
            step_req = 1'b1;
            cycles(1);
            step_req = 1'b0;
            chk({31'h0, step_busy}, 32'h1);
            for (n = 0; n < 50 && step_done !== 1'b1; n++) cycles(1);
            chk({31'h0, step_done}, 32'h1);
            chk(32'(ce_cnt - base), 32'(SP));
            cycles(k * 3);
        end
        base = ce_cnt;
        cycles(20);
        chk(32'(ce_cnt - base), 32'h0);
        dut_flag = 1'b1;
        cycles(1);
        dut_flag = 1'b0;
        acc(1'b0, STATUS_IDX, 32'h0);
        chk(rd, 32'h9);
        acc(1'b1, STATUS_IDX, 32'h1);
        acc(1'b0, STATUS_IDX, 32'h0);
        chk(rd, 32'h8);
        run = 1'b0;
        mode_free_sel = 1'b1;
        cycles(2);
        run = 1'b1;
        cycles(3);
        base = ce_cnt;
        cycles(60);
        chk(32'(ce_cnt - base), 32'(60 * FREQ_50_U / SYS_100_U));
        seed = lfsr(seed);
        dut_out[1] = seed;
        acc(1'b0, 4'h1, 32'h0);
        chk(rd, seed);
        acc(1'b1, 4'h0, seed);
        chk(dut_in[0], seed);
        // Mode request while running must be ignored
        mode_free_sel = 1'b0;
        acc(1'b0, STATUS_IDX, 32'h0);
        chk(rd, 32'hC);
        ce = 1'b0;
        base = ce_cnt;
        cycles(10);
        chk(32'(ce_cnt - base), 32'h0);
        ce = 1'b1;
        cycles(2);
        // Mid-run reset clears port words and the latched mode
        nrst = 1'b0;
        cycles(2);
        chk(dut_in[0] | dut_in[1], 32'h0);
        chk({28'h0, dut_ce, step_busy, step_done, host_ack}, 32'h0);
        nrst = 1'b1;
        acc(1'b0, STATUS_IDX, 32'h0);
        chk(rd, 32'h8);
        cycles(2);
        close_out();
    end
endmodule : cosim_clock_stepper_tb_top
